// ==== design/ltp_map.svh ====
/*
  Register offsets, field positions, reset values and divider counts of the
  legacy timer pair. Assumes 32-bit classic Wishbone with one register per word.
*/
`ifndef LTP_MAP_SVH
`define LTP_MAP_SVH

// Byte offsets of the registers
`define LTP_ADDR_CTRL 8'h00
`define LTP_ADDR_MODE 8'h04
`define LTP_ADDR_CLKSEL 8'h08
`define LTP_ADDR_A_LOW 8'h0C
`define LTP_ADDR_B_LOW 8'h10
`define LTP_ADDR_A_HIGH 8'h14
`define LTP_ADDR_B_HIGH 8'h18
`define LTP_ADDR_IRQEN 8'h1C

// Control register bits
`define LTP_CTRL_A_RUN 4
`define LTP_CTRL_A_OVF 5
`define LTP_CTRL_B_RUN 6
`define LTP_CTRL_B_OVF 7

// Mode register: four bits per timer, timer a in the low nibble
`define LTP_MODE_A_LSB 0
`define LTP_MODE_B_LSB 4

// Clock select register bits
`define LTP_CLK_PS_LSB 0
`define LTP_CLK_A_SYS 3
`define LTP_CLK_B_SYS 4

// Interrupt enable register bits
`define LTP_IRQEN_A 0
`define LTP_IRQEN_B 1

// Reset values
`define LTP_RST_BYTE 8'h00

// Prescaler divisors
`define LTP_DIV_12 6'h0C
`define LTP_DIV_4 6'h04
`define LTP_DIV_48 6'h30
`define LTP_EXT_DIV_LAST 3'h7

`endif

// ==== design/ltp_pkg.sv ====
/*
  Types shared by the legacy timer pair modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ltp_pkg;

  // Operating modes of one timer
  typedef enum logic [1:0] {
    LTP_MODE_13BIT,
    LTP_MODE_16BIT,
    LTP_MODE_RELOAD,
    LTP_MODE_IDLE
  } ltp_mode_type;

  // Shared prescaler choices
  typedef enum logic [1:0] {
    LTP_PS_DIV12,
    LTP_PS_DIV4,
    LTP_PS_DIV48,
    LTP_PS_EXT8
  } ltp_prescale_type;

  // Per-timer nibble of the mode register
  typedef struct packed {
    logic gate_en;
    logic counter_sel;
    ltp_mode_type mode;
  } ltp_tmode_type;

  // Count held in a high and a low byte
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ltp_count_type;

  // Software load of one count byte
  typedef struct packed {
    logic low;
    logic high;
    logic [7:0] data;
  } ltp_load_type;

endpackage : ltp_pkg

// ==== design/ltp_timer_unit.sv ====
/*
  One counter of the timer pair: 13-bit, 16-bit and 8-bit auto-reload modes.
  Assumes tick_i is already gated by run and gate, and loads come from the bus.
*/
`timescale 1ns/1ps
`include "ltp_map.svh"

module ltp_timer_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ltp_pkg::ltp_mode_type mode_i,
  input wire logic tick_i,
  input wire ltp_pkg::ltp_load_type load_i,
  output ltp_pkg::ltp_count_type count_o,
  output logic wrap_o
);
  import ltp_pkg::*;

  ltp_count_type count_q;
  ltp_count_type count_d;
  logic [12:0] next13;
  logic [15:0] next16;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Next count and wrap detection
  always_comb begin
    next13 = {count_q.high, count_q.low[4:0]} + 13'h0001;
    next16 = {count_q.high, count_q.low} + 16'h0001;
    count_d = count_q;
    wrap = 1'h0;
    if (tick_i) begin
      unique case (mode_i)
        LTP_MODE_13BIT: begin
          // Upper low-byte bits take no part in the count
          count_d.high = next13[12:5]; // RULE_01
          count_d.low[4:0] = next13[4:0]; // RULE_01
          wrap = (next13 == 13'h0000); // RULE_02
        end
        LTP_MODE_16BIT: begin
          count_d = next16; // RULE_08
          wrap = (next16 == 16'h0000); // RULE_08
        end
        LTP_MODE_RELOAD: begin
          if (count_q.low == 8'hFF) begin
            count_d.low = count_q.high; // RULE_09
            wrap = 1'h1; // RULE_09
          end else begin
            count_d.low = count_q.low + 8'h01;
          end
        end
        LTP_MODE_IDLE: begin
          count_d = count_q;
        end
      endcase
    end
    // Software loads win over counting for the byte written
    if (load_i.low) begin
      count_d.low = load_i.data;
    end
    if (load_i.high) begin
      count_d.high = load_i.data;
    end
  end

  // Count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= {`LTP_RST_BYTE, `LTP_RST_BYTE};
    end else begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
  assign wrap_o = wrap;

endmodule : ltp_timer_unit

// ==== design/ltp_top.sv ====
/*
  Legacy timer pair, modes 13-bit, 16-bit and 8-bit auto-reload, behind a
  classic Wishbone slave. Assumes one 25 MHz clock, synchronous reset, and
  asynchronous count, gate and external oscillator pins.

// Operation
// RULE_01: 13-bit mode keeps eight upper bits high, five lower in low bits 4..0.
// RULE_02: 13-bit wrap sets the overflow flag; enabled flag raises interrupt.
// RULE_03: Counter select one counts falling edges on the count pin.
// RULE_04: Counter select zero uses system clock or prescaled clock per select bit.
// RULE_05: Advance only with run set and gate clear or gate pin high.
// RULE_06: Setting run never clears or reloads the count.
// RULE_07: Second timer behaves like the first with its own bytes and bits.
// RULE_08: 16-bit mode counts over all sixteen bits, same enabling.
// RULE_09: Reload mode counts low byte, reloads it from high byte on wrap.
// RULE_10: Software loads the low byte before enabling reload mode.
// RULE_11: External events up to a quarter of system clock are counted.
// RULE_12: Count pin levels are held at least two system clock periods.
// RULE_13: Five clock sources from per-timer selects and shared scale field.
// RULE_14: Mode, source and gating are configured separately per timer.
// RULE_15: Scale field picks divide by 12, 4, 48, or external divided by 8.
// RULE_16: Mode field picks 13-bit, 16-bit, auto-reload or inactive.
// RULE_17: Overflow flag clears on interrupt vectoring or software write.
// RULE_18: Count and gate pins pass two flops; edges compare successive samples.
*/
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ltp_map.svh"

module ltp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_input_a_i,
  input wire logic count_input_b_i,
  input wire logic gate_input_a_n_i,
  input wire logic gate_input_b_n_i,
  input wire logic external_osc_clock_i,
  input wire logic irq_ack_a_i,
  input wire logic irq_ack_b_i,
  output logic irq_a_o,
  output logic irq_b_o,
  output ltp_pkg::ltp_prescale_type prescale_o
);
  import ltp_pkg::*;

  // Pin vector order: ext clock, gate b, gate a, count b, count a
  localparam int PIN_CNT = 0;
  localparam int PIN_GATE = 2;
  localparam int PIN_EXT = 4;

  logic [4:0] pins;
  logic [4:0] sync1_q;
  logic [4:0] sync1_d;
  logic [4:0] sync2_q;
  logic [4:0] sync2_d;
  logic [4:0] prev_q;
  logic [4:0] prev_d;

  logic [5:0] ps_cnt_q;
  logic [5:0] ps_cnt_d;
  logic [5:0] ps_div;
  logic [2:0] ext_cnt_q;
  logic [2:0] ext_cnt_d;
  logic ps_tick;
  logic ext_rise;

  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [1:0] ovf_q;
  logic [1:0] ovf_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [1:0] sys_sel_q;
  logic [1:0] sys_sel_d;
  ltp_prescale_type ps_sel_q;
  ltp_prescale_type ps_sel_d;
  logic [1:0] irq_en_q;
  logic [1:0] irq_en_d;

  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic wr_en;
  logic ctrl_wr;

  logic [1:0] fall;
  logic [1:0] enable;
  logic [1:0] tick;
  logic [1:0] wrap;
  logic [1:0] irq_ack;
  ltp_count_type counts [2];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  assign pins = {external_osc_clock_i, gate_input_b_n_i, gate_input_a_n_i,
                 count_input_b_i, count_input_a_i};

  always_comb begin
    sync1_d = pins; // RULE_18
    sync2_d = sync1_q; // RULE_18
    prev_d = sync2_q; // RULE_18
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler producing one-cycle ticks
  assign ext_rise = sync2_q[PIN_EXT] & ~prev_q[PIN_EXT];

  always_comb begin
    unique case (ps_sel_q)
      LTP_PS_DIV12: ps_div = `LTP_DIV_12; // RULE_15
      LTP_PS_DIV4: ps_div = `LTP_DIV_4; // RULE_15
      LTP_PS_DIV48: ps_div = `LTP_DIV_48; // RULE_15
      LTP_PS_EXT8: ps_div = `LTP_DIV_4;
    endcase
    ps_cnt_d = ps_cnt_q;
    ext_cnt_d = ext_cnt_q;
    ps_tick = 1'h0;
    if (ps_sel_q == LTP_PS_EXT8) begin
      // External oscillator edges counted in eighths
      ps_cnt_d = 6'h00;
      if (ext_rise) begin
        ext_cnt_d = ext_cnt_q + 3'h1;
        ps_tick = (ext_cnt_q == `LTP_EXT_DIV_LAST); // RULE_15
      end
    end else begin
      // A divisor change never leaves the counter above its limit
      ext_cnt_d = 3'h0;
      if (ps_cnt_q >= ps_div - 6'h01) begin
        ps_cnt_d = 6'h00;
        ps_tick = 1'h1; // RULE_15
      end else begin
        ps_cnt_d = ps_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_cnt_q <= 6'h00;
      ext_cnt_q <= 3'h0;
    end else begin
      ps_cnt_q <= ps_cnt_d;
      ext_cnt_q <= ext_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: one wait state, ack for one cycle
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign ctrl_wr = wr_en & (wb_adr_i == `LTP_ADDR_CTRL);

  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (req & ~ack_q) begin
      rdata_d = 32'h0000_0000;
      unique case (wb_adr_i)
        `LTP_ADDR_CTRL: begin
          rdata_d[`LTP_CTRL_A_RUN] = run_q[0];
          rdata_d[`LTP_CTRL_A_OVF] = ovf_q[0];
          rdata_d[`LTP_CTRL_B_RUN] = run_q[1];
          rdata_d[`LTP_CTRL_B_OVF] = ovf_q[1];
        end
        `LTP_ADDR_MODE: rdata_d[7:0] = mode_q;
        `LTP_ADDR_CLKSEL: begin
          rdata_d[`LTP_CLK_PS_LSB +: 2] = ps_sel_q;
          rdata_d[`LTP_CLK_A_SYS] = sys_sel_q[0];
          rdata_d[`LTP_CLK_B_SYS] = sys_sel_q[1];
        end
        `LTP_ADDR_A_LOW: rdata_d[7:0] = counts[0].low;
        `LTP_ADDR_B_LOW: rdata_d[7:0] = counts[1].low;
        `LTP_ADDR_A_HIGH: rdata_d[7:0] = counts[0].high;
        `LTP_ADDR_B_HIGH: rdata_d[7:0] = counts[1].high;
        `LTP_ADDR_IRQEN: rdata_d[1:0] = irq_en_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written from the bus
  always_comb begin
    run_d = run_q;
    mode_d = mode_q;
    sys_sel_d = sys_sel_q;
    ps_sel_d = ps_sel_q;
    irq_en_d = irq_en_q;
    if (ctrl_wr) begin
      // Run bits touch no count byte
      run_d[0] = wb_dat_i[`LTP_CTRL_A_RUN]; // RULE_06
      run_d[1] = wb_dat_i[`LTP_CTRL_B_RUN]; // RULE_06
    end
    if (wr_en & (wb_adr_i == `LTP_ADDR_MODE)) begin
      mode_d = wb_dat_i[7:0]; // RULE_14
    end
    if (wr_en & (wb_adr_i == `LTP_ADDR_CLKSEL)) begin
      ps_sel_d = ltp_prescale_type'(wb_dat_i[`LTP_CLK_PS_LSB +: 2]); // RULE_13
      sys_sel_d[0] = wb_dat_i[`LTP_CLK_A_SYS]; // RULE_13
      sys_sel_d[1] = wb_dat_i[`LTP_CLK_B_SYS]; // RULE_13
    end
    if (wr_en & (wb_adr_i == `LTP_ADDR_IRQEN)) begin
      irq_en_d[0] = wb_dat_i[`LTP_IRQEN_A];
      irq_en_d[1] = wb_dat_i[`LTP_IRQEN_B];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 2'h0;
      ovf_q <= 2'h0;
      mode_q <= `LTP_RST_BYTE;
      sys_sel_q <= 2'h0;
      ps_sel_q <= LTP_PS_DIV12;
      irq_en_q <= 2'h0;
    end else begin
      run_q <= run_d;
      ovf_q <= ovf_d;
      mode_q <= mode_d;
      sys_sel_q <= sys_sel_d;
      ps_sel_q <= ps_sel_d;
      irq_en_q <= irq_en_d;
    end
  end

  assign prescale_o = ps_sel_q;
  assign irq_ack = {irq_ack_b_i, irq_ack_a_i};

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer source selection, gating, flags and counter
  for (genvar g = 0; g < 2; g++) begin : gen_timer
    ltp_tmode_type tmode;
    ltp_load_type load;
    logic src_tick;
    logic [7:0] low_addr;
    logic [7:0] high_addr;
    int unsigned ovf_bit;

    assign tmode = ltp_tmode_type'(mode_q[4 * g +: 4]); // RULE_07
    assign low_addr = (g == 0) ? `LTP_ADDR_A_LOW : `LTP_ADDR_B_LOW;
    assign high_addr = (g == 0) ? `LTP_ADDR_A_HIGH : `LTP_ADDR_B_HIGH;
    assign ovf_bit = (g == 0) ? `LTP_CTRL_A_OVF : `LTP_CTRL_B_OVF;

    // Falling edge of the synchronised count pin, up to clk/4 event rate
    assign fall[g] = prev_q[PIN_CNT + g] & ~sync2_q[PIN_CNT + g]; // RULE_03 RULE_11

    // Counter, system clock or prescaled tick
    assign src_tick = tmode.counter_sel ? fall[g] // RULE_03
                    : (sys_sel_q[g] ? 1'h1 : ps_tick); // RULE_04

    // Gate pin high or gating off lets the timer advance
    assign enable[g] = run_q[g] & (~tmode.gate_en | sync2_q[PIN_GATE + g]); // RULE_05
    assign tick[g] = enable[g] & src_tick; // RULE_05

    assign load.low = wr_en & (wb_adr_i == low_addr);
    assign load.high = wr_en & (wb_adr_i == high_addr);
    assign load.data = wb_dat_i[7:0];

    // Wrap sets the flag even when cleared in the same cycle
    assign ovf_d[g] = wrap[g] // RULE_02 RULE_09
                    | (ctrl_wr ? wb_dat_i[ovf_bit] : (ovf_q[g] & ~irq_ack[g])); // RULE_17

    ltp_timer_unit u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(tmode.mode), // RULE_16
      .tick_i(tick[g]),
      .load_i(load),
      .count_o(counts[g]),
      .wrap_o(wrap[g])
    );
  end

  // Interrupt requests follow flag and enable
  assign irq_a_o = ovf_q[0] & irq_en_q[0]; // RULE_02
  assign irq_b_o = ovf_q[1] & irq_en_q[1]; // RULE_02

endmodule : ltp_top

// ==== verif/ltp_pin_model.sv ====
/*
  Pin side partner: count pulses, gate levels and a free external oscillator.
  Assumes the block samples every pin with the 25 MHz system clock.
*/
`timescale 1ns/1ps

module ltp_pin_model (
  input wire logic clk_i,
  output logic count_input_a_o,
  output logic count_input_b_o,
  output logic gate_input_a_n_o,
  output logic gate_input_b_n_o,
  output logic external_osc_clock_o
);
  // Idle pins high so only commanded pulses fall
  initial begin
    count_input_a_o = 1'b1;
    count_input_b_o = 1'b1;
    gate_input_a_n_o = 1'b1;
    gate_input_b_n_o = 1'b1;
  end
  // Oscillator with one rising edge every three system cycles, off the clock edge
  initial begin
    external_osc_clock_o = 1'b0;
    #7;
    forever #60 external_osc_clock_o = ~external_osc_clock_o;
  end
  // Falling edges at a quarter of the clock, each level held two cycles
  task automatic burst(input logic which, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (which) count_input_b_o <= 1'b0;
      else count_input_a_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      count_input_a_o <= 1'b1;
      count_input_b_o <= 1'b1;
      @(posedge clk_i);
    end
  endtask : burst
  // Both gate pins to one level
  task automatic gate(input logic lvl);
    gate_input_a_n_o <= lvl;
    gate_input_b_n_o <= lvl;
  endtask : gate
endmodule : ltp_pin_model

// ==== verif/ltp_top_sva.sv ====
/*
  Port checker for the timer pair: bus handshake, prescale field, interrupt clear.
  Assumes it is bound to ltp_top and sees only its ports.
*/
`timescale 1ns/1ps

module ltp_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_ack_a_i,
  input wire logic irq_ack_b_i,
  input wire logic irq_a_o,
  input wire logic irq_b_o,
  input wire ltp_pkg::ltp_prescale_type prescale_o
);
  import ltp_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Request waiting for its answer, and a completed clock select read
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_clk_read;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
  endsequence
  property p_ack_after;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_dat_upper;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_clk_read;
    s_clk_read |-> wb_dat_o[1:0] == prescale_o && wb_dat_o[7:5] == 3'h0;
  endproperty
  property p_ps_change;
    !$stable(prescale_o) |-> $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2);
  endproperty
  property p_irq_ack_a;
    irq_ack_a_i |-> ##[1:2] !irq_a_o;
  endproperty
  property p_irq_ack_b;
    irq_ack_b_i |-> ##[1:2] !irq_b_o;
  endproperty
  a_ack_after: assert property (p_ack_after) else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
  a_clk_read: assert property (p_clk_read) else $error("clock select read wrong");
  a_ps_change: assert property (p_ps_change) else $error("prescale moved unasked");
  a_irq_ack_a: assert property (p_irq_ack_a) else $error("irq a not cleared");
  a_irq_ack_b: assert property (p_irq_ack_b) else $error("irq b not cleared");
endmodule : ltp_top_sva

bind ltp_top ltp_top_sva u_ltp_top_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_ack_a_i, .irq_ack_b_i, .irq_a_o, .irq_b_o,
  .prescale_o);

// ==== verif/ltp_top_tb_top.sv ====
/*
  Self-checking bench of the timer pair: register bus, modes, sources, gating.
  Assumes the checker is bound by its own file and the pin model drives the pins.
*/
`timescale 1ns/1ps

module ltp_top_tb_top;
  import ltp_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_ack_a_i, irq_ack_b_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, r;
  logic irq_a_o, irq_b_o, count_input_a_i, count_input_b_i;
  logic gate_input_a_n_i, gate_input_b_n_i, external_osc_clock_i;
  ltp_prescale_type prescale_o;
  int bad_count, compares, seed;
  ltp_top u_ltp_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_input_a_i, .count_input_b_i, .gate_input_a_n_i,
    .gate_input_b_n_i, .external_osc_clock_i, .irq_ack_a_i, .irq_ack_b_i, .irq_a_o,
    .irq_b_o, .prescale_o);
  ltp_pin_model u_ltp_pin_model (.clk_i, .count_input_a_o(count_input_a_i),
    .count_input_b_o(count_input_b_i), .gate_input_a_n_o(gate_input_a_n_i),
    .gate_input_b_n_o(gate_input_b_n_i), .external_osc_clock_o(external_osc_clock_i));
  ////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // One classic Wishbone cycle, held until ack is seen
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     output logic [31:0] q);
    int i;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, 24'h0, dat};
    i = 0;
    // Ack and read data are taken at the rising edge, before that edge updates them
    do begin
      @(posedge clk_i);
      q = wb_dat_o;
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      finish_test();
    end else begin
      {wb_cyc_i, wb_stb_i} <= 2'h0;
    end
  endtask : bus
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] q;
    bus(1'b1, adr, dat, q);
  endtask : wr
  // Expected count and wrap after a number of ticks
  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] v, input int n);
    logic w;
    w = 1'b0;
    repeat (n) begin
      case (m)
        2'h0: begin
          w |= ({v[15:8], v[4:0]} == 13'h1FFF);
          {v[15:8], v[4:0]} = {v[15:8], v[4:0]} + 13'h1;
        end
        2'h1: begin
          w |= (v == 16'hFFFF);
          v = v + 16'h1;
        end
        2'h2: begin
          w |= (v[7:0] == 8'hFF);
          v[7:0] = (v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h1;
        end
        default: ;
      endcase
    end
    return {w, v};
  endfunction : step
  // Load, run for a window or a pulse burst, stop, then read back and clear
  task automatic run(input logic t, input logic [3:0] nib, input logic [7:0] cks,
    input logic [15:0] v0, input int src, input int n, input int ticks, input logic en,
    input logic gl);
    logic [16:0] e;
    logic [31:0] q;
    logic [7:0] mk;
    e = step(nib[1:0], v0, ticks);
    mk = (nib[1:0] == 2'h0) ? 8'h1F : 8'hFF;
    u_ltp_pin_model.gate(gl);
    wr(8'h1C, t ? {6'h0, en, 1'b0} : {7'h0, en});
    wr(8'h08, cks);
    bus(1'b0, 8'h08, 8'h00, q);
    chk("clock select", q, {24'h0, cks & 8'h1B});
    wr(8'h04, 8'h33);
    wr(t ? 8'h10 : 8'h0C, v0[7:0]);
    wr(t ? 8'h18 : 8'h14, v0[15:8]);
    wr(8'h00, t ? 8'h40 : 8'h10);
    wr(8'h04, t ? {nib, 4'h3} : {4'h3, nib});
    if (src == 0) repeat (n) @(posedge clk_i);
    else begin
      u_ltp_pin_model.burst(t, n);
      repeat (6) @(posedge clk_i);
    end
    wr(8'h04, 8'h33);
    bus(1'b0, t ? 8'h10 : 8'h0C, 8'h00, q);
    chk("low byte", q & mk, {24'h0, e[7:0] & mk});
    bus(1'b0, t ? 8'h18 : 8'h14, 8'h00, q);
    chk("high byte", q, {24'h0, e[15:8]});
    bus(1'b0, 8'h00, 8'h00, q);
    chk("overflow flag", q[t ? 7 : 5], e[16]);
    chk("irq", t ? irq_b_o : irq_a_o, e[16] & en);
    if (r[11]) wr(8'h00, 8'h00);
    else begin
      @(posedge clk_i);
      {irq_ack_b_i, irq_ack_a_i} <= t ? 2'h2 : 2'h1;
      @(posedge clk_i);
      {irq_ack_b_i, irq_ack_a_i} <= 2'h0;
    end
    bus(1'b0, 8'h00, 8'h00, q);
    chk("flag cleared", q[t ? 7 : 5], 1'b0);
  endtask : run
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 29762;
    r = 32'h0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, irq_ack_a_i, irq_ack_b_i} = 6'h20;
    {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'h1};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'h20, 8'hFF);
    for (int a = 0; a <= 32; a += 4) begin
      bus(1'b0, a[7:0], 8'h00, rd);
      chk("reset value", rd, 32'h0);
    end
    run(1'b0, 4'h0, 8'h18, 16'hFF1E, 0, 2, 5, 1'b1, 1'b1);
    run(1'b1, 4'h1, 8'h18, 16'hFFFD, 0, 1, 4, 1'b0, 1'b1);
    run(1'b0, 4'h2, 8'h18, 16'h80FE, 0, 7, 10, 1'b1, 1'b1);
    run(1'b1, 4'h3, 8'h18, 16'h1234, 0, 5, 8, 1'b1, 1'b1);
    run(1'b0, 4'h9, 8'h18, 16'h0000, 0, 10, 0, 1'b1, 1'b0);
    run(1'b1, 4'h9, 8'h18, 16'h0000, 0, 10, 13, 1'b1, 1'b1);
    run(1'b1, 4'h5, 8'h18, 16'hFFF0, 1, 20, 20, 1'b1, 1'b1);
    run(1'b0, 4'h6, 8'h00, 16'h40FD, 1, 9, 9, 1'b1, 1'b1);
    for (int p = 0; p < 4; p++) begin
      run(p[0], 4'h1, {6'h0, p[1:0]}, 16'h0000, 0, 477, 480 / (p == 0 ? 12 : p == 1 ? 4 :
        p == 2 ? 48 : 24), 1'b1, 1'b1);
    end
    repeat (16) begin
      r = $random(seed);
      run(r[2], {r[3], 1'b0, r[1:0]}, 8'h18, r[31:16], 0, r[9:5],
        (r[3] && !r[4]) ? 0 : r[9:5] + 3, r[10], r[4]);
    end
    finish_test();
  end
endmodule : ltp_top_tb_top
